// File: hw/led_driver_regs.vh
// constants for the gray-level latch pipeline: control fields, defaults, commands
`ifndef LED_DRIVER_REGS_VH
`define LED_DRIVER_REGS_VH

// control latch layout and default
`define CTRL_WIDTH        16
`define CTRL_RESET        16'h0200
`define CTRL_BRIGHT_LSB   4
`define CTRL_BRIGHT_MSB   9
`define CTRL_REFRESH_BIT  10
`define CTRL_TMRST_BIT    11
`define CTRL_COMMIT_WORD_COUNT_SELECT_BIT  15
`define CTRL_USED_MASK    16'h8FF0

// latch geometry
`define WORD_WIDTH        16
`define SLOT_COUNT        16
`define LATCH_WIDTH       256
`define SLOT_TOP          4'hF

// command edge-count ranges (upper bound of each pair)
`define CMD_WORD_WRITE    5'h01
`define CMD_COMMIT        5'h03
`define CMD_CTRL_READ     5'h05
`define CMD_CTRL_WRITE_LO 5'h0A
`define CMD_CTRL_WRITE    5'h0B
`define CMD_TMRST_LO      5'h0C
`define CMD_TMRST         5'h0D
`define CMD_CTRL_ARM_LO   5'h0E
`define CMD_CTRL_ARM      5'h0F

// gray-level timing
`define GS_MAX            16'hFFFF
`define ON_DELAY_EDGE     10'h201

`endif

// File: hw/pin_sync.v
// three-flop synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
    input  wire clk,
    input  wire rst,
    input  wire pin,
    output reg  level_q,
    output reg  rise_q
);
    reg [2:0] sync_q;   // sync_q[0] feeds only sync_q[1]

    // sample the pin, accept a change once stages two and three agree
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[1:0], pin};
            rise_q <= 1'b0;
            if (sync_q[1] == sync_q[2])
            begin
                level_q <= sync_q[2];
                rise_q  <= sync_q[2] & ~level_q;   // new high level
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// File: hw/word_buffer.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_buffer
#(
    parameter WIDTH = 20
)
(
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] head_q;    // oldest entry
    reg [WIDTH-1:0] tail_q;    // second entry
    reg [1:0]       count_q;   // entries held

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data  = head_q;

    // fill and drain in order
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            head_q  <= {WIDTH{1'b0}};
            tail_q  <= {WIDTH{1'b0}};
            count_q <= 2'h0;
        end
        else
        begin
            case ({push, pop})
                2'b10:
                begin
                    if (count_q == 2'h0)
                        head_q <= in_data;
                    else
                        tail_q <= in_data;
                    count_q <= count_q + 2'h1;
                end
                2'b01:
                begin
                    head_q  <= tail_q;
                    count_q <= count_q - 2'h1;
                end
                2'b11:
                begin
                    if (count_q == 2'h1)
                        head_q <= in_data;
                    else
                    begin
                        head_q <= tail_q;
                        tail_q <= in_data;
                    end
                end
                default:
                begin
                    count_q <= count_q;   // idle
                end
            endcase
        end
    end
endmodule // word_buffer
`default_nettype wire

// File: hw/led_gray_level_latch_pipeline.v
// serial port, command decode, three gray-level latches and pwm counter
`timescale 1ns/1ps
`default_nettype none
`include "led_driver_regs.vh"
module led_gray_level_latch_pipeline
#(
    parameter BUF_WIDTH = 20
)
(
    input  wire        clk,
    input  wire        rst,
    input  wire        serial_data_in,
    input  wire        shift_clock,
    input  wire        load_strobe,
    input  wire        gray_level_clock,
    output reg         serial_data_out,
    output reg  [15:0] channel_output,
    output reg  [5:0]  global_brightness,
    output reg         word_buffer_ready
);
    // synchronised pins
    wire sdi_level;      // serial data level
    wire sclk_rise;      // shift clock rising edge
    wire lat_level;      // strobe level
    wire gray_level_clock_rise;     // gray-level clock rising edge

    reg  [15:0]  shift_q;        // common shift register
    reg  [4:0]   edge_cnt_q;     // shift edges while strobe high
    reg          lat_prev_q;     // strobe level one cycle back
    reg  [3:0]   slot_addr_q;    // slot for next word write
    reg  [15:0]  ctrl_q;         // function control latch
    reg          ctrl_armed_q;   // control write permitted
    reg          commit_pend_q;  // commit waiting for buffer drain
    reg  [255:0] first_q;        // first latch
    reg  [255:0] second_q;       // second latch
    reg  [255:0] third_q;        // third latch, drives outputs
    reg          third_valid_q;  // third latch holds written data
    reg          second_new_q;   // second latch loaded by a commit
    reg  [15:0]  gs_cnt_q;       // gray-level counter
    reg          started_q;      // first commit seen
    reg  [9:0]   on_delay_q;     // gs edges since first commit
    reg          display_en_q;   // outputs allowed after start delay
    reg  [255:0] merged;         // first latch with last word merged

    // decoded commands at strobe fall
    wire lat_fall     = lat_prev_q & ~lat_level;
    wire cmd_word     = lat_fall & (edge_cnt_q <= `CMD_WORD_WRITE);
    wire cmd_commit   = lat_fall & (edge_cnt_q > `CMD_WORD_WRITE)
                        & (edge_cnt_q <= `CMD_COMMIT);
    wire cmd_read     = lat_fall & (edge_cnt_q > `CMD_COMMIT)
                        & (edge_cnt_q <= `CMD_CTRL_READ);
    wire cmd_wr_ctrl  = lat_fall & (edge_cnt_q >= `CMD_CTRL_WRITE_LO)
                        & (edge_cnt_q <= `CMD_CTRL_WRITE);
    wire cmd_tmrst    = lat_fall & (edge_cnt_q >= `CMD_TMRST_LO)
                        & (edge_cnt_q <= `CMD_TMRST);
    wire cmd_arm      = lat_fall & (edge_cnt_q >= `CMD_CTRL_ARM_LO)
                        & (edge_cnt_q <= `CMD_CTRL_ARM);

    // control fields
    wire auto_refresh = ~ctrl_q[`CTRL_REFRESH_BIT];
    wire tmrst_en     = ctrl_q[`CTRL_TMRST_BIT];
    wire latmode16    = ctrl_q[`CTRL_COMMIT_WORD_COUNT_SELECT_BIT];
    wire [5:0] bright = ctrl_q[`CTRL_BRIGHT_MSB:`CTRL_BRIGHT_LSB];

    // buffer between command decode and first latch
    wire [BUF_WIDTH-1:0] buf_out;
    wire                 buf_out_valid;
    wire                 buf_in_ready;
    wire                 commit_go = commit_pend_q & ~buf_out_valid;
    wire                 drain_ready = ~commit_pend_q | buf_out_valid;

    // period end and counter clear
    wire period_end   = gray_level_clock_rise & (gs_cnt_q == `GS_MAX);
    wire clear_commit = commit_go & ~auto_refresh;
    wire clear_tmrst  = cmd_tmrst & tmrst_en;

    // pick one 16-bit slot out of a latch
    function [15:0] slot_word;
        input [255:0] latch;
        input [3:0]   idx;
        begin
            slot_word = latch[idx*16 +: 16];
        end
    endfunction

    pin_sync u_sync_sdi
    (
        .clk     (clk),
        .rst     (rst),
        .pin     (serial_data_in),
        .level_q (sdi_level),
        .rise_q  ()
    );

    pin_sync u_sync_sclk
    (
        .clk     (clk),
        .rst     (rst),
        .pin     (shift_clock),
        .level_q (),
        .rise_q  (sclk_rise)
    );

    pin_sync u_sync_lat
    (
        .clk     (clk),
        .rst     (rst),
        .pin     (load_strobe),
        .level_q (lat_level),
        .rise_q  ()
    );

    pin_sync u_sync_gray_level_clock
    (
        .clk     (clk),
        .rst     (rst),
        .pin     (gray_level_clock),
        .level_q (),
        .rise_q  (gray_level_clock_rise)
    );

    word_buffer #(.WIDTH(BUF_WIDTH)) u_word_buffer
    (
        .clk       (clk),
        .rst       (rst),
        .in_data   ({slot_addr_q, shift_q}),
        .in_valid  (cmd_word),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out),
        .out_valid (buf_out_valid),
        .out_ready (drain_ready)
    );

    // shift register, edge counter and strobe history
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            shift_q    <= 16'h0000;
            edge_cnt_q <= 5'h00;
            lat_prev_q <= 1'b0;
        end
        else
        begin
            lat_prev_q <= lat_level;
            if (cmd_read)
                shift_q <= ctrl_q;
            else if (sclk_rise)
                shift_q <= {shift_q[14:0], sdi_level};
            // count shift edges under the strobe, restart when it falls
            if (lat_fall)
                edge_cnt_q <= 5'h00;
            else if (sclk_rise & lat_level & (edge_cnt_q != 5'h1F))
                edge_cnt_q <= edge_cnt_q + 5'h01;
        end
    end

    // slot address counter and commit request
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            slot_addr_q   <= `SLOT_TOP;
            commit_pend_q <= 1'b0;
        end
        else
        begin
            // rewind when the commit is applied, so the merge still sees the last slot
            if (commit_go)
                slot_addr_q <= `SLOT_TOP;
            else if (cmd_word & buf_in_ready)
                slot_addr_q <= slot_addr_q - 4'h1;
            // a commit waits until queued words reach the first latch
            if (cmd_commit)
                commit_pend_q <= 1'b1;
            else if (commit_go)
                commit_pend_q <= 1'b0;
        end
    end

    // control latch with write arming
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q       <= `CTRL_RESET;
            ctrl_armed_q <= 1'b0;
        end
        else
        begin
            if (cmd_wr_ctrl & ctrl_armed_q)
            begin
                ctrl_q       <= shift_q & `CTRL_USED_MASK;
                ctrl_armed_q <= 1'b0;
            end
            else if (cmd_arm)
                ctrl_armed_q <= 1'b1;
        end
    end

    // first latch with the final word merged in fifteen-write mode
    always @*
    begin
        merged = first_q;
        if (~latmode16)
            merged[slot_addr_q*16 +: 16] = shift_q;
    end

    // first, second and third latches
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            first_q       <= 256'h0;
            second_q      <= 256'h0;
            third_q       <= 256'h0;
            third_valid_q <= 1'b0;
            second_new_q  <= 1'b0;
        end
        else
        begin
            if (buf_out_valid & drain_ready)
                first_q[buf_out[19:16]*16 +: 16] <= buf_out[15:0];
            else if (commit_go)
                first_q <= merged;
            // every commit refreshes the second latch
            if (commit_go)
                second_q <= merged;
            // direct load without refresh, else the period-end copy
            if (commit_go & ~auto_refresh)
            begin
                third_q       <= merged;
                third_valid_q <= 1'b1;
                second_new_q  <= 1'b0;
            end
            else
            begin
                // period end still copies when a commit lands in the same cycle
                if (period_end & auto_refresh)
                begin
                    third_q <= second_q;
                    if (second_new_q)
                        third_valid_q <= 1'b1;
                end
                // a fresh commit wins over the period-end clear
                if (commit_go)
                    second_new_q <= 1'b1;
                else if (period_end & auto_refresh)
                    second_new_q <= 1'b0;
            end
        end
    end

    // gray-level counter, first-commit flag and start delay
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gs_cnt_q     <= 16'h0000;
            started_q    <= 1'b0;
            on_delay_q   <= 10'h000;
            display_en_q <= 1'b0;
        end
        else
        begin
            if (clear_commit | clear_tmrst)
            begin
                gs_cnt_q    <= 16'h0000;
            end
            else if (gray_level_clock_rise)
            begin
                gs_cnt_q    <= gs_cnt_q + 16'h0001;
            end
            if (commit_go)
                started_q <= 1'b1;
            // enable one edge early, so the next edge (ON_DELAY_EDGE) is the first to drive
            if (started_q & gray_level_clock_rise & ~display_en_q)
            begin
                on_delay_q <= on_delay_q + 10'h001;
                if (on_delay_q == (`ON_DELAY_EDGE - 10'h002))
                    display_en_q <= 1'b1;
            end
        end
    end

    // pwm outputs and registered port copies
    always @(posedge clk or posedge rst)
    begin : out_proc
        integer ch;
        if (rst)
        begin
            channel_output    <= 16'h0000;
            serial_data_out   <= 1'b0;
            global_brightness <= 6'h00;
            word_buffer_ready <= 1'b0;
        end
        else
        begin
            serial_data_out   <= shift_q[15];
            global_brightness <= bright;
            word_buffer_ready <= buf_in_ready;
            if (clear_commit | clear_tmrst)
                channel_output <= 16'h0000;
            else if (gray_level_clock_rise)
            begin
                for (ch = 0; ch < `SLOT_COUNT; ch = ch + 1)
                    channel_output[ch] <= display_en_q & third_valid_q
                        & (bright != 6'h00)
                        & (gs_cnt_q < slot_word(third_q, ch[3:0]));
            end
        end
    end
endmodule // led_gray_level_latch_pipeline
`default_nettype wire

// File: dv/led_latch_monitor.sv
// assertion checker watching the latch pipeline top-level ports
`timescale 1ns/1ps
`default_nettype none
module led_latch_monitor
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        serial_data_in,
    input wire logic        shift_clock,
    input wire logic        load_strobe,
    input wire logic        gray_level_clock,
    input wire logic        serial_data_out,
    input wire logic [15:0] channel_output,
    input wire logic [5:0]  global_brightness,
    input wire logic        word_buffer_ready
);
    logic [5:0] sh_q; // clocks since shift clock rise
    logic [5:0] lf_q; // clocks since strobe fall
    logic [5:0] gr_q; // clocks since gray clock rise
    // saturating age counters of pin events
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sh_q <= 6'h00;
            lf_q <= 6'h00;
            gr_q <= 6'h00;
        end
        else
        begin
            sh_q <= $rose(shift_clock) ? 6'h00 : sh_q + {5'h00, ~&sh_q};
            lf_q <= $fell(load_strobe) ? 6'h00 : lf_q + {5'h00, ~&lf_q};
            gr_q <= $rose(gray_level_clock) ? 6'h00 : gr_q + {5'h00, ~&gr_q};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_release;
        $fell(rst);
    endsequence
    sequence s_dark_gray;
        ($rose(gray_level_clock) && global_brightness == 6'h00) ##0
        (global_brightness == 6'h00) [*8];
    endsequence
    AST_SERIAL_DATA_OUT_CAUSE: assert property ($changed(serial_data_out) |-> sh_q < 6'h10 || lf_q < 6'h10)
        else $error("serial out moved without shift or command");
    AST_OUT_CAUSE: assert property ($changed(channel_output) |-> gr_q < 6'h10 || lf_q < 6'h10)
        else $error("outputs moved without gray edge or command");
    AST_BRIGHT_CAUSE: assert property ($changed(global_brightness) |-> lf_q < 6'h10)
        else $error("brightness moved without command");
    AST_DARK_OFF: assert property (s_dark_gray |-> channel_output == 16'h0000)
        else $error("outputs on with zero brightness");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        rst |-> channel_output == 16'h0000 && serial_data_out == 1'b0)
        else $error("outputs not cleared in reset");
    AST_BRIGHT_DEFAULT: assert property (s_release |-> ##[0:1] global_brightness == 6'h20)
        else $error("brightness default wrong");
    AST_READY_RESET: assert property (s_release |-> ##[0:1] word_buffer_ready)
        else $error("buffer not ready after reset");
    AST_READY_IDLE: assert property (lf_q == 6'h3F |-> word_buffer_ready)
        else $error("buffer not drained when idle");
endmodule // led_latch_monitor
bind led_gray_level_latch_pipeline led_latch_monitor mon_u (.clk(clk), .rst(rst),
    .serial_data_in(serial_data_in), .shift_clock(shift_clock), .load_strobe(load_strobe),
    .gray_level_clock(gray_level_clock), .serial_data_out(serial_data_out),
    .channel_output(channel_output), .global_brightness(global_brightness),
    .word_buffer_ready(word_buffer_ready));
`default_nettype wire

// File: dv/led_controller_model.sv
// display controller model driving the serial link pins
`timescale 1ns/1ps
`default_nettype none
module led_controller_model
(
    input  wire logic clk,
    output var  logic serial_data_in,
    output var  logic shift_clock,
    output var  logic load_strobe,
    input  wire logic serial_data_out
);
    logic [15:0] rd_q; // word seen on serial out
    // pins idle low at start
    initial
    begin
        serial_data_in = 1'b0;
        shift_clock    = 1'b0;
        load_strobe    = 1'b0;
        rd_q           = 16'h0000;
    end
    // shift a word msb first, strobe high over last n rises, 320 ns clock
    task automatic xfer(input logic [15:0] d, input int n, input logic cmd);
        for (int i = 15; i >= 0; i--)
        begin
            serial_data_in = d[i];
            load_strobe    = cmd && (i < n);
            repeat (4) @(negedge clk);
            rd_q[i]     = serial_data_out;
            shift_clock = 1'b1;
            repeat (4) @(negedge clk);
            shift_clock = 1'b0;
        end
        load_strobe = cmd;
        repeat (4) @(negedge clk);
        load_strobe    = 1'b0;
        serial_data_in = ~serial_data_in; // released line shows no stale bit
        repeat (16) @(negedge clk);
    endtask
endmodule // led_controller_model
`default_nettype wire

// File: dv/led_gray_level_latch_pipeline_bench.sv
// self-checking bench for the gray-level latch pipeline
`timescale 1ns/1ps
`default_nettype none
module led_gray_level_latch_pipeline_bench;
    logic        clk;               // 25 MHz clock
    logic        rst;               // async reset
    logic        gray_level_clock;  // pwm clock pin
    wire         serial_data_in;    // link pins from model
    wire         shift_clock;
    wire         load_strobe;
    wire         serial_data_out;
    wire  [15:0] channel_output;
    wire  [5:0]  global_brightness;
    wire         word_buffer_ready;
    int          failures;
    int          check_count;
    int          cycles;
    led_gray_level_latch_pipeline dut_u (.clk(clk), .rst(rst),
        .serial_data_in(serial_data_in), .shift_clock(shift_clock),
        .load_strobe(load_strobe), .gray_level_clock(gray_level_clock),
        .serial_data_out(serial_data_out), .channel_output(channel_output),
        .global_brightness(global_brightness), .word_buffer_ready(word_buffer_ready));
    led_controller_model ctl_u (.clk(clk), .serial_data_in(serial_data_in),
        .shift_clock(shift_clock), .load_strobe(load_strobe),
        .serial_data_out(serial_data_out));
    always #20 clk = ~clk;
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // k gray clock periods of 8 clocks, then settle
    task automatic gray(input int k);
        repeat (k)
        begin
            gray_level_clock = 1'b1;
            repeat (4) @(negedge clk);
            gray_level_clock = 1'b0;
            repeat (4) @(negedge clk);
        end
        repeat (8) @(negedge clk);
    endtask
    // read control latch back through serial out
    task automatic rdctl();
        ctl_u.xfer(16'h0000, 4, 1'b1);
        ctl_u.xfer(16'h0000, 0, 1'b0);
    endtask
    // arm then write control latch
    task automatic wrctl(input logic [15:0] v);
        ctl_u.xfer(16'h0000, 14, 1'b1);
        ctl_u.xfer(v, 10, 1'b1);
    endtask
    // slot s gets base plus s steps; fifteen-write mode sends slot 0 with the commit
    task automatic words(input logic [15:0] base, input logic [15:0] step, input logic all16);
        for (int s = 15; s >= 0; s--)
            if (all16 || s > 0)
                ctl_u.xfer(base + step * s[15:0], 0, 1'b1);
        ctl_u.xfer(all16 ? 16'h0000 : base, 2, 1'b1);
    endtask
    // main sequence
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        gray_level_clock = 1'b0;
        failures = 0;
        check_count = 0;
        cycles = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("brightness", 16'h0020, {10'h000, global_brightness});
        chk("outputs", 16'h0000, channel_output);
        chk("serial out", 16'h0000, {15'h0000, serial_data_out});
        rdctl();
        chk("control read", 16'h0200, ctl_u.rd_q);
        ctl_u.xfer(16'hA5C3, 0, 1'b0);
        ctl_u.xfer(16'h0000, 0, 1'b0);
        chk("shift path", 16'hA5C3, ctl_u.rd_q);
        ctl_u.xfer(16'hF7F0, 10, 1'b1);
        rdctl();
        chk("unarmed write", 16'h0200, ctl_u.rd_q);
        wrctl(16'hF7F0);
        rdctl();
        chk("masked write", 16'h87F0, ctl_u.rd_q);
        chk("brightness", 16'h003F, {10'h000, global_brightness});
        words(16'h0200, 16'h0010, 1'b1);
        chk("outputs", 16'h0000, channel_output);
        gray(512);
        chk("outputs", 16'h0000, channel_output);
        gray(1);
        chk("outputs", 16'hFFFE, channel_output);
        gray(87);
        chk("outputs", 16'hFFC0, channel_output);
        ctl_u.xfer(16'h0000, 2, 1'b1);
        chk("outputs", 16'h0000, channel_output);
        gray(600);
        chk("outputs", 16'hFFC0, channel_output);
        wrctl(16'h83F0);
        words(16'h0000, 16'h0000, 1'b1);
        chk("outputs", 16'hFFC0, channel_output);
        gray(100);
        chk("outputs", 16'hF000, channel_output);
        ctl_u.xfer(16'h0000, 12, 1'b1);
        gray(40);
        chk("outputs", 16'h8000, channel_output);
        wrctl(16'h8BF0);
        ctl_u.xfer(16'h0000, 12, 1'b1);
        chk("outputs", 16'h0000, channel_output);
        gray(600);
        chk("outputs", 16'hFFC0, channel_output);
        wrctl(16'h8800);
        gray(1);
        chk("brightness", 16'h0000, {10'h000, global_brightness});
        chk("outputs", 16'h0000, channel_output);
        // fifteen-write mode: the commit word must land in slot 0
        wrctl(16'h07F0);
        words(16'h0100, 16'h0040, 1'b0);
        gray(200);
        chk("outputs", 16'hFFFF, channel_output);
        gray(100);
        chk("outputs", 16'hFFFE, channel_output);
        report_and_stop();
    end
endmodule // led_gray_level_latch_pipeline_bench
`default_nettype wire
